// ==== watchdog_register_interface.v ====
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.vh"
module watchdog_register_interface #(
  parameter NUM_REQ = 8,
  parameter LF_DIV = `LF_DIV_CYCLES
) (
  // Clock and reset.
  input wire clock,
  input wire nrst,
  // Register port.
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  // System status pins.
  input wire cpu_sleeping,
  input wire debug_halted,
  // Events and requests.
  output reg expiry_event,
  output reg watchdog_reset_request,
  output reg irq
);
  reg sleep_s1, sleep_s2, halt_s1, halt_s2;
  reg [15:0] div_count;
  reg lf_tick;
  reg running;
  reg inten;
  reg [31:0] reload_value;
  reg [NUM_REQ-1:0] req_enables;
  reg cfg_sleep_run, cfg_halt_run;
  reg [NUM_REQ-1:0] req_pending;
  reg [31:0] counter;
  reg reset_armed;
  reg [1:0] reset_delay;
  reg expiry_flag;
  reg irq_status, irq_mask;
  wire req_region = (addr >= `OFF_RELOAD_REQ) &&
                    (addr < `OFF_RELOAD_REQ + NUM_REQ * 4);
  wire [2:0] req_index = addr[4:2];
  wire magic_wr = wr && req_region && (wdata == `RELOAD_MAGIC);
  wire start_wr = wr && (addr == `OFF_START) && wdata[0];
  wire cfg_open = !running;
  wire paused = (sleep_s2 && !cfg_sleep_run) ||
                (halt_s2 && !cfg_halt_run);
  reg [NUM_REQ-1:0] next_pending;
  reg grant;

  // Status pins come from other domains; two flops before use.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
    end else begin
      sleep_s1 <= cpu_sleeping;
      sleep_s2 <= sleep_s1;
      halt_s1 <= debug_halted;
      halt_s2 <= halt_s1;
    end
  end

  // Low-frequency tick derived from the system clock. The ratio is not
  // integral, so the tick rate is approximate by about 0.06 percent.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_count <= 16'h0000;
      lf_tick <= 1'b0;
    end else if (div_count == LF_DIV - 1) begin
      div_count <= 16'h0000;
      lf_tick <= 1'b1;
    end else begin
      div_count <= div_count + 16'h0001;
      lf_tick <= 1'b0;
    end
  end

  // A grant happens when every enabled word holds a pending magic write.
  always @* begin
    next_pending = req_pending;
    if (magic_wr && req_index < NUM_REQ)
      next_pending[req_index] = 1'b1;
    grant = running && ((next_pending & req_enables) == req_enables);
  end

  // Configuration and interrupt enable registers.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      inten <= 1'b0;
      reload_value <= `RST_RELOAD_VALUE;
      req_enables <= `RST_REQ_ENABLES;
      cfg_sleep_run <= `RST_SLEEP_RUN;
      cfg_halt_run <= `RST_HALT_RUN;
      irq_mask <= 1'b0;
    end else if (wr) begin
      if (addr == `OFF_INTEN_SET && wdata[0])
        inten <= 1'b1;
      if (addr == `OFF_INTEN_CLR && wdata[0])
        inten <= 1'b0;
      if (addr == `OFF_IRQ_MASK)
        irq_mask <= wdata[0];
      if (cfg_open) begin
        if (addr == `OFF_RELOAD_VALUE)
          reload_value <= wdata;
        if (addr == `OFF_REQ_ENABLES)
          req_enables <= wdata[NUM_REQ-1:0];
        if (addr == `OFF_PAUSE_CFG) begin
          cfg_sleep_run <= wdata[`CFG_SLEEP_BIT];
          cfg_halt_run <= wdata[`CFG_HALT_BIT];
        end
      end
    end
  end

  // Counter, request tracking and expiry.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      running <= 1'b0;
      counter <= 32'h00000000;
      req_pending <= {NUM_REQ{1'b0}};
      expiry_event <= 1'b0;
    end else begin
      expiry_event <= 1'b0;
      if (start_wr && !running) begin
        running <= 1'b1;
        counter <= reload_value;
        req_pending <= {NUM_REQ{1'b0}};
      end else if (grant) begin
        counter <= reload_value;
        req_pending <= {NUM_REQ{1'b0}};
      end else begin
        if (running)
          req_pending <= next_pending;
        if (running && lf_tick && !paused) begin
          counter <= counter - 32'h00000001;
          if (counter == 32'h00000000)
            expiry_event <= 1'b1;
        end
      end
    end
  end

  // Once armed, the reset cannot be withdrawn; only a system reset ends it.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reset_armed <= 1'b0;
      reset_delay <= 2'h0;
      watchdog_reset_request <= 1'b0;
    end else if (expiry_event && !reset_armed) begin
      reset_armed <= 1'b1;
      reset_delay <= inten ? `RESET_DELAY_TICKS : 2'h0;
      if (!inten)
        watchdog_reset_request <= 1'b1;
    end else if (reset_armed && !watchdog_reset_request) begin
      if (reset_delay == 2'h0)
        watchdog_reset_request <= 1'b1;
      else if (lf_tick)
        reset_delay <= reset_delay - 2'h1;
    end
  end

  // Sticky expiry flag and interrupt status; the set wins over a clear.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      expiry_flag <= 1'b0;
      irq_status <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (expiry_event)
        expiry_flag <= 1'b1;
      else if (wr && addr == `OFF_EXPIRY && !wdata[0])
        expiry_flag <= 1'b0;
      if (expiry_event)
        irq_status <= 1'b1;
      else if (rd && addr == `OFF_IRQ_STATUS)
        irq_status <= 1'b0;
      irq <= (irq_status || expiry_event) && irq_mask && inten;
    end
  end

  // Read port: data stand in the cycle after the strobe. Request words
  // are write-only and read as zero like unmapped space.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `OFF_EXPIRY: rdata <= {31'h0, expiry_flag};
        `OFF_INTEN_SET: rdata <= {31'h0, inten};
        `OFF_INTEN_CLR: rdata <= {31'h0, inten};
        `OFF_RUN_STATE: rdata <= {31'h0, running};
        `OFF_REQ_STATE: rdata <= {{(32-NUM_REQ){1'b0}},
                                  req_enables & ~req_pending};
        `OFF_RELOAD_VALUE: rdata <= reload_value;
        `OFF_REQ_ENABLES: rdata <= {{(32-NUM_REQ){1'b0}}, req_enables};
        `OFF_PAUSE_CFG: rdata <= {28'h0, cfg_halt_run, 2'h0, cfg_sleep_run};
        `OFF_IRQ_STATUS: rdata <= {31'h0, irq_status};
        `OFF_IRQ_MASK: rdata <= {31'h0, irq_mask};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule // watchdog_register_interface
`default_nettype wire

// ==== watchdog_defines.vh ====
`ifndef WATCHDOG_DEFINES_VH
`define WATCHDOG_DEFINES_VH
`define ADDR_W 12
`define OFF_START 12'h000
`define OFF_EXPIRY 12'h100
`define OFF_INTEN_SET 12'h304
`define OFF_INTEN_CLR 12'h308
`define OFF_RUN_STATE 12'h400
`define OFF_REQ_STATE 12'h404
`define OFF_RELOAD_VALUE 12'h504
`define OFF_REQ_ENABLES 12'h508
`define OFF_PAUSE_CFG 12'h50c
`define OFF_RELOAD_REQ 12'h600
`define OFF_IRQ_STATUS 12'h700
`define OFF_IRQ_MASK 12'h704
`define RST_REQ_ENABLES 8'h01
`define RST_RELOAD_VALUE 32'h00000000
`define RST_SLEEP_RUN 1'b1
`define RST_HALT_RUN 1'b0
`define CFG_SLEEP_BIT 0
`define CFG_HALT_BIT 3
`define RELOAD_MAGIC 32'h6e524635
`define SYS_CLOCK_HZ 50000000
`define LF_CLOCK_HZ 32768
`define LF_DIV_CYCLES (`SYS_CLOCK_HZ / `LF_CLOCK_HZ)
`define RESET_DELAY_TICKS 2'd2
`endif

// ==== watchdog_checker_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.vh"
module watchdog_checker (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Register port.
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Outputs.
  input wire logic expiry_event,
  input wire logic watchdog_reset_request,
  input wire logic irq
);
  logic ien;
  logic running;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Shadow state is rebuilt from bus writes so no body signal is needed.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ien <= 1'b0;
      running <= 1'b0;
    end else begin
      if (wr && addr == `OFF_INTEN_SET && wdata[0]) ien <= 1'b1;
      if (wr && addr == `OFF_INTEN_CLR && wdata[0]) ien <= 1'b0;
      if (wr && addr == `OFF_START && wdata[0]) running <= 1'b1;
    end
  end
  a_set_reads_enable: assert property (rd && addr == `OFF_INTEN_SET |=>
    rdata == {31'h0, $past(ien)}) else $error("enable set read wrong");
  a_clr_reads_enable: assert property (rd && addr == `OFF_INTEN_CLR |=>
    rdata == {31'h0, $past(ien)}) else $error("enable clear read wrong");
  a_irq_needs_enable: assert property (!ien |=> !irq)
    else $error("interrupt while disabled");
  a_expiry_when_running: assert property (expiry_event |-> running)
    else $error("expiry before start");
  a_reset_stays_high: assert property (watchdog_reset_request |=>
    watchdog_reset_request) else $error("reset request dropped");
  a_reset_postponed: assert property (expiry_event && ien |=>
    !watchdog_reset_request [*4]) else $error("reset not postponed");
  a_request_reads_zero: assert property (rd && addr == `OFF_RELOAD_REQ |=>
    rdata == 32'h0) else $error("request word readable");
  a_enables_eight_bits: assert property (rd && addr == `OFF_REQ_ENABLES |=>
    rdata[31:8] == 24'h0) else $error("enable bits too wide");
endmodule // watchdog_checker
bind watchdog_register_interface watchdog_checker i_chk (.clock(clock),
  .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .expiry_event(expiry_event), .irq(irq),
  .watchdog_reset_request(watchdog_reset_request));
`default_nettype wire

// ==== watchdog_register_interface_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defines.vh"
module watchdog_register_interface_test;
  logic clock = 0, nrst = 0, wr = 0, rd = 0;
  logic cpu_sleeping = 0, debug_halted = 0;
  logic [`ADDR_W-1:0] addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic expiry_event, watchdog_reset_request, irq;
  int mismatches = 0, compares = 0, i;
  always #10 clock = ~clock;
  watchdog_register_interface #(.NUM_REQ(8), .LF_DIV(4)) i_dut (.clock(clock),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cpu_sleeping(cpu_sleeping), .debug_halted(debug_halted),
    .expiry_event(expiry_event), .irq(irq),
    .watchdog_reset_request(watchdog_reset_request));
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock); wr <= 1; addr <= a; wdata <= d;
    @(posedge clock); wr <= 0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task rreg(input logic [11:0] a, input logic [31:0] e);
    @(posedge clock); rd <= 1; addr <= a;
    @(posedge clock); rd <= 0;
    #1 chk(rdata, e);
  endtask
  task t_reset;
    rreg(`OFF_REQ_ENABLES, 32'h1);
    rreg(`OFF_PAUSE_CFG, 32'h1);
    rreg(`OFF_INTEN_SET, 32'h0);
  endtask
  task t_inten;
    wreg(`OFF_INTEN_SET, 32'h1);
    rreg(`OFF_INTEN_SET, 32'h1);
    wreg(`OFF_INTEN_CLR, 32'h0);
    rreg(`OFF_INTEN_CLR, 32'h1);
    wreg(`OFF_INTEN_CLR, 32'h1);
    rreg(`OFF_INTEN_SET, 32'h0);
    wreg(`OFF_INTEN_SET, 32'h1);
  endtask
  task t_lock;
    @(posedge clock); cpu_sleeping <= 1;
    wreg(`OFF_RELOAD_VALUE, 32'h3);
    wreg(`OFF_REQ_ENABLES, 32'h5);
    rreg(`OFF_REQ_ENABLES, 32'h5);
    wreg(`OFF_PAUSE_CFG, 32'h8);
    rreg(`OFF_PAUSE_CFG, 32'h8);
    wreg(`OFF_IRQ_MASK, 32'h1);
    wreg(`OFF_START, 32'h1);
    rreg(`OFF_RUN_STATE, 32'h1);
    wreg(`OFF_RELOAD_VALUE, 32'h7);
    wreg(`OFF_REQ_ENABLES, 32'hff);
    rreg(`OFF_RELOAD_VALUE, 32'h3);
    rreg(`OFF_REQ_ENABLES, 32'h5);
  endtask
  task t_request;
    rreg(`OFF_REQ_STATE, 32'h5);
    wreg(`OFF_RELOAD_REQ, 32'h0);
    rreg(`OFF_REQ_STATE, 32'h5);
    wreg(`OFF_RELOAD_REQ, `RELOAD_MAGIC);
    rreg(`OFF_REQ_STATE, 32'h4);
    rreg(`OFF_RELOAD_REQ, 32'h0);
    wreg(`OFF_RELOAD_REQ + 12'h008, `RELOAD_MAGIC);
    rreg(`OFF_REQ_STATE, 32'h5);
  endtask
  task t_expiry;
    i = 0;
    repeat (60) begin @(posedge clock); #1 i += expiry_event; end
    chk(i, 0);
    @(posedge clock); cpu_sleeping <= 0; debug_halted <= 1;
    i = 0;
    while (expiry_event !== 1'b1 && i < 40) begin @(posedge clock); #1 i++; end
    chk(expiry_event, 1'b1);
    chk(watchdog_reset_request, 1'b0);
    repeat (2) @(posedge clock);
    #1 chk(irq, 1'b1);
    repeat (20) @(posedge clock);
    #1 chk(watchdog_reset_request, 1'b1);
    rreg(`OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    #1 chk(irq, 1'b0);
  endtask
  task test_done;
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1;
    t_reset;
    t_inten;
    t_lock;
    t_request;
    t_expiry;
    test_done;
  end
endmodule // watchdog_register_interface_test
`default_nettype wire
